// File: logic/pds_defines.vh
// Register map, field positions, reset values and timing counts of the phase-shift block.
`ifndef PDS_DEFINES_VH
`define PDS_DEFINES_VH

`define PDS_ADDR_W 8
`define PDS_OFS_CTRL 8'h00
`define PDS_OFS_STATUS 8'h04
`define PDS_OFS_FB_TAP 8'h08
`define PDS_OFS_POST_TAP 8'h0C
`define PDS_OFS_STEPS 8'h10
`define PDS_OFS_INT_STAT 8'h14
`define PDS_OFS_INT_MASK 8'h18

`define PDS_CTRL_PIN_EN 0
`define PDS_CTRL_GO 1
`define PDS_CTRL_UP 2
`define PDS_CTRL_SEL_LSB 4
`define PDS_CTRL_RESET 32'h0000_0001

`define PDS_STAT_DONE 0
`define PDS_STAT_BUSY 1
`define PDS_STAT_UP 2
`define PDS_STAT_SEL_LSB 4

`define PDS_INT_W 3
`define PDS_INT_COMPLETE 0
`define PDS_INT_REFUSED 1
`define PDS_INT_BAD_SEL 2
`define PDS_INT_MASK_RESET 3'h0

`define PDS_SEL_ALL 4'h0
`define PDS_SEL_FEEDBACK 4'h1
`define PDS_SEL_POST_BASE 4'h2

`define PDS_TAP_RESET 3'h0
`define PDS_SETTLE_CYCLES 3

`endif

// File: logic/pds_phase_shift.v
// Dynamic phase-shift control port of a PLL with an AHB-Lite register slave.
`include "pds_defines.vh"
`default_nettype none

module pds_phase_shift #(
    parameter NUM_POST = 10,
    parameter TAP_W = 3,
    parameter SETTLE_CYCLES = `PDS_SETTLE_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    output reg irq,
    input wire [3:0] counter_select,
    input wire shift_up,
    input wire shift_request,
    output reg phase_done,
    output reg [TAP_W-1:0] feedback_tap,
    output reg [NUM_POST*TAP_W-1:0] post_scale_tap
);

    localparam ST_IDLE = 2'b00;
    localparam ST_ARM = 2'b01;
    localparam ST_SHIFT = 2'b10;
    localparam CNT_W = 8;
    // The settle count is held in eight bits, so settle times above 255 cycles are cut.
    // That bounds the done-low time the core must tolerate.
    localparam [CNT_W-1:0] SETTLE = SETTLE_CYCLES[CNT_W-1:0];

    // Bit 0 of the mask is the feedback counter, bits 1 up are the post-scale counters.
    // Selects 12 to 15 give an empty mask; the handshake still runs so the core never hangs.
    function [NUM_POST:0] pds_decode;
        input [3:0] sel;
        reg [3:0] idx;
        begin
            pds_decode = {(NUM_POST + 1){1'b0}};
            idx = sel - `PDS_SEL_POST_BASE;
            if (sel == `PDS_SEL_ALL) begin
                pds_decode[NUM_POST:1] = {NUM_POST{1'b1}};
            end else if (sel == `PDS_SEL_FEEDBACK) begin
                pds_decode[0] = 1'b1;
            end else if (sel >= `PDS_SEL_POST_BASE && idx < NUM_POST) begin
                pds_decode[idx + 4'h1] = 1'b1;
            end
        end
    endfunction

    // One step is one eighth of a VCO period; the tap wraps so shifting never runs out.
    function [TAP_W-1:0] pds_step;
        input [TAP_W-1:0] tap;
        input up;
        begin
            pds_step = up ? tap + 1'b1 : tap - 1'b1;
        end
    endfunction

    // Register decode shared by every write strobe.
    function pds_hit;
        input [`PDS_ADDR_W-1:0] addr;
        input [`PDS_ADDR_W-1:0] ofs;
        begin
            pds_hit = (addr == ofs);
        end
    endfunction

    reg req_fall;
    reg req_seen;
    reg [1:0] state;
    reg [CNT_W-1:0] settle_cnt;
    reg from_sw;
    reg last_up;
    reg [3:0] last_sel;
    reg [15:0] steps;
    reg pin_en;
    reg sw_go;
    reg sw_up;
    reg [3:0] sw_sel;
    reg [`PDS_INT_W-1:0] int_stat;
    reg [`PDS_INT_W-1:0] int_mask;
    reg wr_pend;
    reg rd_pend;
    reg [`PDS_ADDR_W-1:0] ap_addr;
    reg [31:0] rd_mux;
    reg [NUM_POST:0] next_mask;
    reg next_up;
    reg [3:0] next_sel;
    reg [`PDS_INT_W-1:0] int_set;
    integer i;

    // Only a fresh rise counts, so a request held high for many cycles still gives one step.
    // The core must drop and raise the request again for the next shift.
    wire req_edge = req_fall & ~req_seen;
    wire pin_start = req_edge & pin_en;
    wire take = hsel & hready & htrans[1];
    wire wr_ctrl = wr_pend & pds_hit(ap_addr, `PDS_OFS_CTRL);
    wire wr_stat = wr_pend & pds_hit(ap_addr, `PDS_OFS_INT_STAT);
    wire wr_mask = wr_pend & pds_hit(ap_addr, `PDS_OFS_INT_MASK);
    wire go_write = wr_ctrl & hwdata[`PDS_CTRL_GO];
    wire new_req = pin_start | sw_go;
    wire start = (state == ST_ARM);
    wire finish = (state == ST_SHIFT) && (settle_cnt <= 8'h01);

    // The request is caught half a cycle after the core drives it, away from its switching edge.
    // Everything else in the block runs on the rising edge of the same clock.
    // No synchroniser is needed because the core launches the request from this clock.
    always @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_fall <= 1'b0;
        end else begin
            req_fall <= shift_request;
        end
    end

    always @* begin
        next_up = from_sw ? sw_up : shift_up;
        next_sel = from_sw ? sw_sel : counter_select;
        next_mask = pds_decode(next_sel);
        int_set = {`PDS_INT_W{1'b0}};
        int_set[`PDS_INT_COMPLETE] = finish;
        // A request during a shift is dropped rather than queued, so software can see that
        // its core broke the handshake.
        int_set[`PDS_INT_REFUSED] = (state != ST_IDLE) & (req_edge | sw_go);
        int_set[`PDS_INT_BAD_SEL] = start & (next_mask == {(NUM_POST + 1){1'b0}});
    end

    // Sequencer: request seen on one rising edge, shifting starts on the next.
    // Select and direction are taken only at the start edge, so the core may change them
    // any time after that edge without disturbing a shift in progress.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_seen <= 1'b0;
            state <= ST_IDLE;
            settle_cnt <= {CNT_W{1'b0}};
            from_sw <= 1'b0;
            last_up <= 1'b0;
            last_sel <= 4'h0;
            steps <= 16'h0000;
            phase_done <= 1'b1;
            feedback_tap <= `PDS_TAP_RESET;
            post_scale_tap <= {NUM_POST{`PDS_TAP_RESET}};
        end else begin
            req_seen <= req_fall;
            case (state)
                ST_IDLE: begin
                    // A pin request wins over a software go in the same cycle; the go is then
                    // dropped and not flagged as refused, as that flag needs a non-idle state.
                    if (new_req) begin
                        state <= ST_ARM;
                        from_sw <= ~pin_start;
                    end
                end
                ST_ARM: begin
                    last_up <= next_up;
                    last_sel <= next_sel;
                    steps <= steps + 16'h0001;
                    phase_done <= 1'b0;
                    settle_cnt <= SETTLE;
                    state <= ST_SHIFT;
                    // Only tap selections move; the counters and their outputs keep toggling.
                    if (next_mask[0]) begin
                        feedback_tap <= pds_step(feedback_tap, next_up);
                    end
                    for (i = 0; i < NUM_POST; i = i + 1) begin
                        if (next_mask[i + 1]) begin
                            post_scale_tap[i*TAP_W +: TAP_W] <=
                                pds_step(post_scale_tap[i*TAP_W +: TAP_W], next_up);
                        end
                    end
                end
                ST_SHIFT: begin
                    if (finish) begin
                        phase_done <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        // The counter stands in for the internal settle time of the tap
                        // multiplexers, which the core cannot observe any other way.
                        settle_cnt <= settle_cnt - 8'h01;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    phase_done <= 1'b1;
                end
            endcase
        end
    end

    // Control and interrupt registers; a status event wins over a clear in the same cycle.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_en <= 1'b1;
            sw_go <= 1'b0;
            sw_up <= 1'b0;
            sw_sel <= 4'h0;
            int_stat <= {`PDS_INT_W{1'b0}};
            int_mask <= `PDS_INT_MASK_RESET;
            irq <= 1'b0;
        end else begin
            sw_go <= go_write;
            if (wr_ctrl) begin
                pin_en <= hwdata[`PDS_CTRL_PIN_EN];
                sw_up <= hwdata[`PDS_CTRL_UP];
                sw_sel <= hwdata[`PDS_CTRL_SEL_LSB +: 4];
            end
            if (wr_stat) begin
                int_stat <= (int_stat & ~hwdata[`PDS_INT_W-1:0]) | int_set;
            end else begin
                int_stat <= int_stat | int_set;
            end
            if (wr_mask) begin
                int_mask <= hwdata[`PDS_INT_W-1:0];
            end
            // The line follows the status one cycle late so that it comes from a flip-flop.
            irq <= |(int_stat & int_mask);
        end
    end

    always @* begin
        rd_mux = 32'h0000_0000;
        case (ap_addr)
            `PDS_OFS_CTRL: begin
                rd_mux[`PDS_CTRL_PIN_EN] = pin_en;
                rd_mux[`PDS_CTRL_UP] = sw_up;
                rd_mux[`PDS_CTRL_SEL_LSB +: 4] = sw_sel;
            end
            `PDS_OFS_STATUS: begin
                rd_mux[`PDS_STAT_DONE] = phase_done;
                rd_mux[`PDS_STAT_BUSY] = (state != ST_IDLE);
                rd_mux[`PDS_STAT_UP] = last_up;
                rd_mux[`PDS_STAT_SEL_LSB +: 4] = last_sel;
            end
            `PDS_OFS_FB_TAP: rd_mux[TAP_W-1:0] = feedback_tap;
            `PDS_OFS_POST_TAP: rd_mux[NUM_POST*TAP_W-1:0] = post_scale_tap;
            `PDS_OFS_STEPS: rd_mux[15:0] = steps;
            `PDS_OFS_INT_STAT: rd_mux[`PDS_INT_W-1:0] = int_stat;
            `PDS_OFS_INT_MASK: rd_mux[`PDS_INT_W-1:0] = int_mask;
            // Unmapped offsets read as zero and never raise an error response.
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Reads take one wait state so that a write just before them is already visible.
    // Only word transfers are supported; the transfer size is not checked.
    // The response is always OKAY.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ap_addr <= {`PDS_ADDR_W{1'b0}};
        end else begin
            hresp <= 1'b0;
            if (rd_pend) begin
                hrdata <= rd_mux;
                hreadyout <= 1'b1;
                rd_pend <= 1'b0;
                wr_pend <= 1'b0;
            end else if (take) begin
                ap_addr <= haddr[`PDS_ADDR_W-1:0];
                wr_pend <= hwrite;
                rd_pend <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wr_pend <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// File: testbench/pds_phase_shift_assertions.sv
// Port-level checks of the phase-shift block.
`default_nettype none
module pds_phase_shift_assertions #(
    parameter NUM_POST = 10,
    parameter TAP_W = 3,
    parameter SETTLE_CYCLES = 3
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic shift_up,
    input wire logic shift_request,
    input wire logic [3:0] counter_select,
    input wire logic phase_done,
    input wire logic [TAP_W-1:0] feedback_tap,
    input wire logic [NUM_POST*TAP_W-1:0] post_scale_tap
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] low_cnt;
    // Counts the cycles the done flag has spent low, so the settle length can be judged.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) low_cnt <= 8'h00;
        else low_cnt <= phase_done ? 8'h00 : low_cnt + 8'h01;
    end
    sequence step_seen;
        $past(shift_request, 2) && !$past(shift_request, 3);
    endsequence
    sequence rd_gap;
        !hreadyout ##1 hreadyout;
    endsequence
    req_done_a: assert property ($rose(shift_request) && phase_done |-> ##2 !phase_done)
        else $error("done flag did not fall two edges after request");
    done_cause_a: assert property ($fell(phase_done) |-> step_seen)
        else $error("done flag fell without a fresh request");
    done_len_a: assert property ($rose(phase_done) |-> low_cnt == SETTLE_CYCLES)
        else $error("done flag low time wrong");
    tap_when_a: assert property ($changed(feedback_tap) || $changed(post_scale_tap)
        |-> $fell(phase_done)) else $error("tap moved outside a shift");
    fb_step_a: assert property ($fell(phase_done) && $past(counter_select) == 4'h1
        |-> feedback_tap == ($past(shift_up) ? $past(feedback_tap) + 1'b1
        : $past(feedback_tap) - 1'b1)) else $error("feedback tap step wrong");
    all_sel_a: assert property ($fell(phase_done) && $past(counter_select) == 4'h0
        |-> $stable(feedback_tap) && post_scale_tap != $past(post_scale_tap))
        else $error("select all stepped wrong counters");
    fb_only_a: assert property ($fell(phase_done) && $past(counter_select) inside {1, [12:15]}
        |-> $stable(post_scale_tap)) else $error("post tap moved for other select");
    read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> rd_gap)
        else $error("read wait state wrong");
endmodule
bind pds_phase_shift pds_phase_shift_assertions #(
    .NUM_POST(NUM_POST), .TAP_W(TAP_W), .SETTLE_CYCLES(SETTLE_CYCLES)
) chk_u (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .shift_up,
    .shift_request, .counter_select, .phase_done, .feedback_tap, .post_scale_tap);
`default_nettype wire

// File: testbench/pds_ctrl_model.sv
// Core-side controller that runs one phase-shift handshake per call.
`default_nettype none
module pds_ctrl_model (
    input wire logic hclk,
    input wire logic phase_done,
    output logic [3:0] counter_select,
    output logic shift_up,
    output logic shift_request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        counter_select = 4'h0;
        shift_up = 1'b0;
        shift_request = 1'b0;
    end
    // Called just after a rising edge; lag stretches the waits before raising and before dropping the request to act as a slow core.
    task automatic step(input logic [3:0] s, input logic u, input int lag, output logic ok);
        int n;
        n = 0;
        counter_select <= s;
        shift_up <= u;
        repeat (1 + lag) @(posedge hclk);
        shift_request <= 1'b1;
        @(posedge hclk);
        while (phase_done === 1'b1 && n < 50) begin
            @(posedge hclk);
            n++;
        end
        repeat (lag) @(posedge hclk);
        shift_request <= 1'b0;
        while (phase_done !== 1'b1 && n < 100) begin
            @(posedge hclk);
            n++;
        end
        ok = n < 100;
    endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench of the phase-shift block.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, ok;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, fb_exp;
    logic [2:0] ep [10];
    logic [3:0] counter_select;
    logic shift_up, shift_request, phase_done;
    logic [2:0] feedback_tap;
    logic [29:0] post_scale_tap;
    int mismatches, compares;
    assign hready = hreadyout;
    pds_phase_shift dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hresp, .hrdata, .irq, .counter_select, .shift_up,
        .shift_request, .phase_done, .feedback_tap, .post_scale_tap);
    pds_ctrl_model ctl_u (.hclk, .phase_done, .counter_select, .shift_up, .shift_request);
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    task automatic close_out;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r);
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic shift(input logic [3:0] s, input logic u, input int lag);
        ctl_u.step(s, u, lag, ok);
        chk({31'h0, ok}, 32'h1);
        if (s == 4'h1) fb_exp = u ? fb_exp + 3'h1 : fb_exp - 3'h1;
        for (int k = 0; k < 10; k++) begin
            if (s == 4'h0 || k + 2 == s) ep[k] = u ? ep[k] + 3'h1 : ep[k] - 3'h1;
        end
        chk({29'h0, feedback_tap}, {29'h0, fb_exp});
        for (int k = 0; k < 10; k++) chk({29'h0, post_scale_tap[3*k+:3]}, {29'h0, ep[k]});
    endtask
    task automatic t_reset;
        chk({31'h0, phase_done}, 32'h1);
        bus(8'h00, 1'b0, 32'h0, rd);
        chk(rd, 32'h1);
        bus(8'h18, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
    endtask
    task automatic t_feedback;
        shift(4'h1, 1'b1, 0);
        shift(4'h1, 1'b1, 2);
        shift(4'h1, 1'b0, 0);
        bus(8'h04, 1'b0, 32'h0, rd);
        chk(rd & 32'hF7, 32'h11);
        bus(8'h10, 1'b0, 32'h0, rd);
        chk(rd & 32'hFFFF, 32'h3);
    endtask
    task automatic t_post;
        for (int k = 2; k < 12; k++) shift(4'(k), 1'(k), k % 2);
        repeat (9) shift(4'h2, 1'b1, 0);
        shift(4'h0, 1'b0, 1);
    endtask
    task automatic t_irq;
        bus(8'h14, 1'b1, 32'h7, rd);
        bus(8'h18, 1'b1, 32'h1, rd);
        shift(4'h1, 1'b1, 0);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h1);
        bus(8'h14, 1'b1, 32'h1, rd);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        bus(8'h18, 1'b1, 32'h0, rd);
        shift(4'hC, 1'b1, 1);
        repeat (2) @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        bus(8'h14, 1'b0, 32'h0, rd);
        chk(rd & 32'h4, 32'h4);
        bus(8'h1C, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'h2;
        haddr = 32'h0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hwdata = 32'h0;
        fb_exp = 3'h0;
        foreach (ep[k]) ep[k] = 3'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_feedback();
        t_post();
        t_irq();
        close_out();
    end
    // Far longer than the whole sequence, so only a hang reaches it.
    initial begin
        #200us;
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
